// ---- include/hbc_regs.vh ----
`ifndef HBC_REGS_VH
`define HBC_REGS_VH

// Three-level strap codes
`define HBC_STRAP_PD200 2'h0
`define HBC_STRAP_PU200 2'h1
`define HBC_STRAP_PD10 2'h2

// Raw strap detector results (from analog sense)
`define HBC_DET_PD200 2'h0
`define HBC_DET_PU200 2'h1
`define HBC_DET_PD10 2'h2

// Flash probe
`define HBC_SIG_ADDR 16'hFFFA
`define HBC_EXEC_ADDR 16'h0000
`define HBC_SIG_WORD 32'h32444655
`define HBC_SIG_BYTES 3'h4

// SPI flash commands
`define HBC_CMD_READ 8'h03
`define HBC_CMD_DREAD 8'h3B

// SMBus register that closes host configuration
`define HBC_SOC_DONE_REG 8'hFF

// Timing
`define HBC_CLK_NS 10
`define HBC_PLL_LOCK_NS 1000
`define HBC_PLL_LOCK_CYC ((`HBC_PLL_LOCK_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)

`endif

// ---- hw/hbc_strap_decode.v ----
`timescale 1ns/10ps
`include "hbc_regs.vh"

// Maps a raw three-level detection to a two-bit code
module hbc_strap_decode (
   // Raw detection
   input wire [1:0] det,
   // Decoded code
   output reg [1:0] code
);

   always @* begin
      case (det)
         `HBC_DET_PU200: code = `HBC_STRAP_PU200;
         `HBC_DET_PD10: code = `HBC_STRAP_PD10;
         default: code = `HBC_STRAP_PD200;
      endcase
   end

endmodule

// ---- hw/hbc_flash_probe.v ----
`timescale 1ns/10ps
`include "hbc_regs.vh"

// Reads the four signature bytes from flash, single or dual bit
module hbc_flash_probe #(
   parameter DIV = 2
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   input wire ce,
   // Control
   input wire start,
   input wire dual,
   input wire cpol,
   output reg done,
   output reg match,
   // Flash pins
   output reg flash_sck,
   output reg flash_cs_n,
   output reg flash_mosi,
   output reg flash_mosi_oe_n,
   input wire flash_miso,
   input wire flash_io1
);

   localparam S_IDLE = 3'h1;
   localparam S_SEND = 3'h2;
   localparam S_RECV = 3'h4;

   reg [2:0] st_q;
   reg [5:0] bit_q;
   reg [31:0] sh_q;
   reg [31:0] rx_q;
   reg [7:0] div_q;
   reg ph_q;
   reg dual_q;
   wire tick = (div_q == DIV - 1);
   wire [6:0] last_send = 7'h27;
   wire [5:0] last_recv = dual_q ? 6'h0F : 6'h1F;
   wire [7:0] cmd_w = dual ? `HBC_CMD_DREAD : `HBC_CMD_READ;

   always @(posedge clk) begin
      if (rst) begin
         st_q <= S_IDLE;
         bit_q <= 6'h00;
         sh_q <= 32'h0000_0000;
         rx_q <= 32'h0000_0000;
         div_q <= 8'h00;
         ph_q <= 1'b0;
         dual_q <= 1'b0;
         done <= 1'b0;
         match <= 1'b0;
         flash_sck <= 1'b0;
         flash_cs_n <= 1'b1;
         flash_mosi <= 1'b0;
         flash_mosi_oe_n <= 1'b1;
      end else if (ce) begin
         done <= 1'b0;
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         case (st_q)
            S_IDLE: begin
               flash_sck <= cpol;
               if (start) begin
                  dual_q <= dual;
                  sh_q <= {cmd_w, 8'h00, `HBC_SIG_ADDR};
                  st_q <= S_SEND;
                  bit_q <= 6'h00;
                  ph_q <= 1'b0;
                  // Park clock low so mode 3 also meets a rising edge first
                  flash_sck <= 1'b0;
                  flash_cs_n <= 1'b0;
                  flash_mosi_oe_n <= 1'b0;
                  flash_mosi <= cmd_w[7];
               end
            end
            S_SEND: if (tick) begin
               // Mode 0 and mode 3: shift on falling, sample on rising
               ph_q <= ~ph_q;
               flash_sck <= ~ph_q ? 1'b1 : 1'b0;
               if (ph_q) begin
                  sh_q <= {sh_q[30:0], 1'b0};
                  flash_mosi <= sh_q[30];
                  if ({1'b0, bit_q} == last_send[6:0] - 7'h08) begin
                     st_q <= S_RECV;
                     bit_q <= 6'h00;
                     flash_mosi_oe_n <= 1'b1;
                  end else begin
                     bit_q <= bit_q + 6'h01;
                  end
               end
            end
            S_RECV: if (tick) begin
               ph_q <= ~ph_q;
               flash_sck <= ~ph_q ? 1'b1 : 1'b0;
               if (~ph_q) begin
                  rx_q <= dual_q ? {rx_q[29:0], flash_io1, flash_miso} : {rx_q[30:0], flash_io1};
               end else if (bit_q == last_recv) begin
                  st_q <= S_IDLE;
                  flash_cs_n <= 1'b1;
                  done <= 1'b1;
                  match <= (rx_q == `HBC_SIG_WORD);
               end else begin
                  bit_q <= bit_q + 6'h01;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

endmodule

// ---- hw/hbc_boot_seq.v ----
`timescale 1ns/10ps
`include "hbc_regs.vh"

// Summary of operation
// [RULE_01] Non-removable strap: 200k down none, 200k up port 1, 10k down ports 1-2.
// [RULE_02] Charging strap: 200k down off, 200k up port 1, 10k down ports 1-2.
// [RULE_03] Reset input low keeps standby: ports high impedance, PLL stopped.
// [RULE_04] Reset input high runs hub mode through the boot stages.
// [RULE_05] Standby disables ports, aborts work, returns all state to defaults.
// [RULE_06] After release: reset logic, lock PLL with valid clock, load defaults, then probe.
// [RULE_07] SPI mode probes signature at 0xFFFA; match runs flash from 0x0000.
// [RULE_08] Without SPI mode the flash probe is skipped for ROM default load.
// [RULE_09] External flash must be 1 Mbit or more and 60 MHz or faster.
// [RULE_10] Flash reads are single or dual bit, in clock mode 0 or 3.
// [RULE_11] Default load takes ROM values, then strap values override them.
// [RULE_12] Strap stage registers mode strap; SMBus goes host config, else merge. The code latches smbus_mode in ST_INIT instead.
// [RULE_13] Host config waits with no timeout until register 0xFF is written.
// [RULE_14] Merge combines ROM, host-written and one-time data and applies it.
// [RULE_15] Idle and suspend without VBUS; with VBUS go charger detect or connect.
// [RULE_16] After charger detect enter connect; attach while VBUS stays high.
// [RULE_17] Normal mode gives full hub operation until the system changes mode.
// [RULE_18] Reset input low from any stage returns to standby.
// [RULE_19] Soft disconnect returns normal mode to connect until it is removed.
// [RULE_20] All strap levels are latched at reset release and used afterwards.
// [RULE_21] Pull-ups on both mode pins select SMBus; neither pull selects SPI.
// [RULE_22] Straps are two-bit codes; unknown detection reads as 200k pull-down.
module hbc_boot_seq #(
   parameter CFG_W = 16,
   parameter SPI_DIV = 2,
   parameter PLL_LOCK_CYC = `HBC_PLL_LOCK_CYC,
   parameter [15:0] ROM_DEFAULT = 16'h0000
) (
   // Clock, reset, enable
   input wire clk,
   input wire rst,
   input wire ce,
   input wire reset_n,
   // Analog strap detections
   input wire [1:0] nonremovable_strap,
   input wire [1:0] charging_strap,
   input wire mode_do_pullup,
   input wire mode_clk_pullup,
   // Clock health and flash options
   input wire clk_valid,
   input wire pll_locked,
   input wire flash_dual,
   input wire flash_cpol,
   // Host configuration over SMBus and one-time data
   input wire soc_wr,
   input wire [7:0] soc_addr,
   input wire [CFG_W-1:0] soc_data,
   input wire [CFG_W-1:0] otp_data,
   input wire otp_valid,
   // Bus and USB status
   input wire vbus,
   input wire charger_detect_done,
   input wire usb_configured,
   input wire soft_disconnect,
   // Flash pins
   output wire flash_sck,
   output wire flash_cs_n,
   output wire flash_mosi,
   output wire flash_mosi_oe_n,
   input wire flash_miso,
   input wire flash_io1,
   // Status outputs
   output reg pll_enable,
   output reg ports_hiz,
   output reg [1:0] nonremovable_code,
   output reg [1:0] charging_code,
   output reg [1:0] nonremovable_ports,
   output reg [1:0] charging_ports,
   output reg smbus_mode,
   output reg exec_external,
   output reg [15:0] exec_addr,
   output reg [CFG_W-1:0] final_cfg,
   output reg cfg_applied,
   output reg suspend,
   output reg charger_detect_stage,
   output reg usb_attach,
   output reg normal_mode,
   output reg [10:0] stage
);

   // ==========================================
   // Stage encodings
   localparam ST_STANDBY = 11'h001;
   localparam ST_INIT = 11'h002;
   localparam ST_PROBE = 11'h004;
   localparam ST_CFG_RD = 11'h008;
   localparam ST_STRAP = 11'h010;
   localparam ST_SOC = 11'h020;
   localparam ST_MERGE = 11'h040;
   localparam ST_IDLE = 11'h080;
   localparam ST_CHARGER_DETECT_STAGE = 11'h100;
   localparam ST_CONNECT = 11'h200;
   localparam ST_NORMAL = 11'h400;

   // ==========================================
   // Strap decoding
   wire [1:0] nr_dec;
   wire [1:0] bc_dec;

   hbc_strap_decode u_nr (
      .det(nonremovable_strap),
      .code(nr_dec)
   ); // see [RULE_22]

   hbc_strap_decode u_bc (
      .det(charging_strap),
      .code(bc_dec)
   ); // see [RULE_22]

   function [1:0] ports_of;
      input [1:0] c;
      begin
         case (c)
            `HBC_STRAP_PU200: ports_of = 2'h1;
            `HBC_STRAP_PD10: ports_of = 2'h3;
            default: ports_of = 2'h0;
         endcase
      end
   endfunction

   // ==========================================
   // Flash probe
   reg probe_start_q;
   wire probe_done;
   wire probe_match;

   hbc_flash_probe #(
      .DIV(SPI_DIV)
   ) u_probe (
      .clk(clk),
      .rst(rst | ~reset_n),
      .ce(ce),
      .start(probe_start_q),
      .dual(flash_dual),
      .cpol(flash_cpol),
      .done(probe_done),
      .match(probe_match),
      .flash_sck(flash_sck),
      .flash_cs_n(flash_cs_n),
      .flash_mosi(flash_mosi),
      .flash_mosi_oe_n(flash_mosi_oe_n),
      .flash_miso(flash_miso),
      .flash_io1(flash_io1)
   ); // see [RULE_10]

   // ==========================================
   // Sequencer
   reg [15:0] lock_q;
   reg [CFG_W-1:0] base_cfg_q;
   reg [CFG_W-1:0] soc_cfg_q;
   reg [CFG_W-1:0] soc_mask_q;
   reg latched_q;
   wire bc_on = (charging_code != `HBC_STRAP_PD200);

   always @(posedge clk) begin
      if (rst || !reset_n) begin
         // Standby wipes everything back to defaults
         stage <= ST_STANDBY; // see [RULE_03] see [RULE_18]
         pll_enable <= 1'b0;
         ports_hiz <= 1'b1; // see [RULE_05]
         nonremovable_code <= `HBC_STRAP_PD200;
         charging_code <= `HBC_STRAP_PD200;
         nonremovable_ports <= 2'h0;
         charging_ports <= 2'h0;
         smbus_mode <= 1'b0;
         exec_external <= 1'b0;
         exec_addr <= 16'h0000;
         final_cfg <= {CFG_W{1'b0}};
         cfg_applied <= 1'b0;
         suspend <= 1'b0;
         charger_detect_stage <= 1'b0;
         usb_attach <= 1'b0;
         normal_mode <= 1'b0;
         lock_q <= 16'h0000;
         base_cfg_q <= {CFG_W{1'b0}};
         soc_cfg_q <= {CFG_W{1'b0}};
         soc_mask_q <= {CFG_W{1'b0}};
         latched_q <= 1'b0;
         probe_start_q <= 1'b0;
      end else if (ce) begin
         probe_start_q <= 1'b0;
         case (stage)
            ST_STANDBY: begin
               stage <= ST_INIT; // see [RULE_04]
            end
            ST_INIT: begin
               if (!latched_q) begin
                  // Straps captured once, right after release
                  latched_q <= 1'b1;
                  nonremovable_code <= nr_dec; // see [RULE_20] see [RULE_01]
                  charging_code <= bc_dec; // see [RULE_20] see [RULE_02]
                  smbus_mode <= mode_do_pullup & mode_clk_pullup; // see [RULE_21]
                  base_cfg_q <= ROM_DEFAULT[CFG_W-1:0];
               end
               pll_enable <= clk_valid; // see [RULE_06]
               if (clk_valid && pll_locked && lock_q >= PLL_LOCK_CYC[15:0]) begin
                  if (!smbus_mode) begin
                     stage <= ST_PROBE;
                     probe_start_q <= 1'b1; // see [RULE_07]
                  end else begin
                     stage <= ST_CFG_RD; // see [RULE_08]
                  end
               end else if (clk_valid) begin
                  lock_q <= lock_q + 16'h0001;
               end
            end
            ST_PROBE: begin
               if (probe_done) begin
                  if (probe_match) begin
                     exec_external <= 1'b1; // see [RULE_07]
                     exec_addr <= `HBC_EXEC_ADDR;
                  end
                  stage <= ST_CFG_RD;
               end
            end
            ST_CFG_RD: begin
               // Strap override of ROM defaults
               nonremovable_ports <= ports_of(nonremovable_code); // see [RULE_11]
               charging_ports <= ports_of(charging_code); // see [RULE_11]
               stage <= ST_STRAP;
            end
            ST_STRAP: begin
               stage <= smbus_mode ? ST_SOC : ST_MERGE; // see [RULE_12]
            end
            ST_SOC: begin
               // No timeout by design
               if (soc_wr) begin
                  if (soc_addr == `HBC_SOC_DONE_REG) begin
                     stage <= ST_MERGE; // see [RULE_13]
                  end else begin
                     soc_cfg_q <= soc_data;
                     soc_mask_q <= {CFG_W{1'b1}};
                  end
               end
            end
            ST_MERGE: begin
               // Host values beat ROM, one-time data layered on top
               final_cfg <= ((base_cfg_q & ~soc_mask_q) | (soc_cfg_q & soc_mask_q))
                  | (otp_valid ? otp_data : {CFG_W{1'b0}}); // see [RULE_14]
               cfg_applied <= 1'b1;
               ports_hiz <= 1'b0;
               stage <= ST_IDLE;
            end
            ST_IDLE: begin
               suspend <= ~vbus; // see [RULE_15]
               if (vbus) begin
                  if (bc_on) begin
                     stage <= ST_CHARGER_DETECT_STAGE;
                     charger_detect_stage <= 1'b1;
                  end else begin
                     stage <= ST_CONNECT;
                  end
               end
            end
            ST_CHARGER_DETECT_STAGE: begin
               if (charger_detect_done) begin
                  charger_detect_stage <= 1'b0;
                  stage <= ST_CONNECT; // see [RULE_16]
               end
            end
            ST_CONNECT: begin
               usb_attach <= vbus & ~soft_disconnect; // see [RULE_16]
               if (!vbus) begin
                  stage <= ST_IDLE;
               end else if (usb_configured && !soft_disconnect) begin
                  stage <= ST_NORMAL;
                  normal_mode <= 1'b1;
               end
            end
            ST_NORMAL: begin
               if (soft_disconnect || !vbus) begin
                  normal_mode <= 1'b0; // see [RULE_19]
                  usb_attach <= 1'b0;
                  stage <= vbus ? ST_CONNECT : ST_IDLE;
               end // see [RULE_17]
            end
            default: stage <= ST_STANDBY;
         endcase
      end
   end

endmodule

// ---- testbench/hbc_boot_checker.sv ----
`timescale 1ns/10ps
// ==========
// Boot sequencer checks
module hbc_boot_checker (
   // Clock and reset
   input wire clk,
   input wire rst,
   input wire ce,
   input wire reset_n,
   // Inputs watched
   input wire soc_wr,
   input wire [7:0] soc_addr,
   input wire vbus,
   input wire soft_disconnect,
   // Outputs watched
   input wire flash_cs_n,
   input wire flash_mosi_oe_n,
   input wire pll_enable,
   input wire ports_hiz,
   input wire [1:0] nonremovable_code,
   input wire [1:0] charging_code,
   input wire [1:0] nonremovable_ports,
   input wire [1:0] charging_ports,
   input wire smbus_mode,
   input wire exec_external,
   input wire cfg_applied,
   input wire suspend,
   input wire [10:0] stage
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   standby_state_a: assert property (!reset_n |=> stage == 11'h001 && ports_hiz && !pll_enable)
      else $error("standby state wrong");
   release_init_a: assert property (ce && reset_n && stage[0] |=> stage[1])
      else $error("no init after release");
   flash_probe_a: assert property (!flash_cs_n |-> stage[2])
      else $error("flash selected outside probe");
   mosi_drive_a: assert property (!flash_mosi_oe_n |-> !flash_cs_n)
      else $error("data line driven while deselected");
   strap_branch_a: assert property (ce && reset_n && stage[4] |=>
      stage[5] == smbus_mode && stage[6] != smbus_mode)
      else $error("strap branch wrong");
   soc_done_a: assert property (ce && reset_n && stage[5] && soc_wr && soc_addr == 8'hFF |=>
      stage[6])
      else $error("host done ignored");
   soc_wait_a: assert property (ce && reset_n && stage[5] && !(soc_wr && soc_addr == 8'hFF) |=>
      stage[5])
      else $error("host wait left early");
   merge_apply_a: assert property ($rose(stage[7]) && $past(stage[6]) |-> cfg_applied && !ports_hiz)
      else $error("config not applied");
   vbus_branch_a: assert property (ce && reset_n && stage[7] && vbus |=>
      (charging_code != 2'h0 ? stage[8] : stage[9]))
      else $error("vbus branch wrong");
   idle_suspend_a: assert property (stage[7] && $past(stage[7]) && $past(ce) && $past(vbus) == vbus |->
      suspend == !vbus)
      else $error("suspend wrong");
   soft_disc_a: assert property (ce && reset_n && vbus && stage[10] && soft_disconnect |=> stage[9])
      else $error("soft disconnect ignored");
   strap_map_a: assert property (stage[7] |->
      nonremovable_ports == {nonremovable_code[1], |nonremovable_code} &&
      charging_ports == {charging_code[1], |charging_code})
      else $error("port map wrong");
   cover property (stage[5] && soc_wr && soc_addr == 8'hFF);
   cover property (stage[7] && exec_external);
   cover property (stage[10] && soft_disconnect);
endmodule
bind hbc_boot_seq hbc_boot_checker u_hbc_boot_checker (.clk(clk), .rst(rst), .ce(ce), .reset_n(reset_n),
   .soc_wr(soc_wr), .soc_addr(soc_addr), .vbus(vbus), .soft_disconnect(soft_disconnect), .flash_cs_n(flash_cs_n),
   .flash_mosi_oe_n(flash_mosi_oe_n),
   .pll_enable(pll_enable), .ports_hiz(ports_hiz), .nonremovable_code(nonremovable_code),
   .charging_code(charging_code), .nonremovable_ports(nonremovable_ports), .charging_ports(charging_ports),
   .smbus_mode(smbus_mode), .exec_external(exec_external), .cfg_applied(cfg_applied), .suspend(suspend),
   .stage(stage));

// ---- testbench/hbc_flash_model.sv ----
`timescale 1ns/10ps
// ==========
// Serial flash holding a four-byte header at the probed address
module hbc_flash_model (
   // Flash pins
   input wire sck,
   input wire cs_n,
   input wire mosi,
   output reg io0,
   output reg io1,
   // Read width, stored header, captured command
   input wire dual,
   input wire [31:0] data,
   output reg [31:0] hdr
);
   integer n = 0;
   initial begin
      io0 = 1'b0;
      io1 = 1'b1;
      hdr = 32'h0;
   end
   always @(negedge cs_n) begin
      n = 0;
   end
   // Command and address enter on the rising clock in mode 0 and mode 3
   always @(posedge sck) begin
      if (!cs_n) begin
         if (n < 32) begin
            hdr = {hdr[30:0], mosi};
         end
         n = n + 1;
      end
   end
   // Data leaves on the falling clock; released lines show the inverse
   always @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         io0 <= ~io0;
         io1 <= ~io1;
      end else if (dual && n >= 32 && n < 48) begin
         {io1, io0} <= data[95 - 2 * n -: 2];
      end else if (!dual && n >= 32 && n < 64) begin
         io1 <= data[63 - n];
      end
   end
endmodule

// ---- testbench/hbc_boot_seq_test.sv ----
`timescale 1ns/10ps
`include "hbc_regs.vh"
module hbc_boot_seq_test;
   localparam [15:0] ROM = 16'h1200;
   localparam [15:0] OTP = 16'h00A5;
   localparam [31:0] SIG = `HBC_SIG_WORD;
   reg clk = 1'b0, rst = 1'b1, reset_n = 1'b0, mode_do = 1'b0, mode_clk = 1'b0, dual = 1'b0, cpol = 1'b0;
   reg soc_wr = 1'b0, vbus = 1'b0, chg_done = 1'b0, usb_cfg = 1'b0, soft_disc = 1'b0, cs_seen = 1'b0;
   reg ce = 1'b1, otp_v = 1'b1;
   reg [1:0] nr_det = 2'h0, ch_det = 2'h0;
   reg [7:0] soc_addr = 8'h0;
   reg [15:0] soc_data = 16'h0;
   reg [31:0] fdata = 32'h0;
   wire sck, cs_n, mosi, io0, io1, pll_en, hiz, smb, exec_ext, applied, susp, attach, normal;
   wire moe_n, chg;
   wire [1:0] nr_code, ch_code, nr_ports, ch_ports;
   wire [15:0] exec_addr, final_cfg;
   wire [10:0] stage;
   wire [31:0] hdr;
   integer n_errors = 0, n_compared = 0, cycles = 0, i;
   hbc_boot_seq #(.SPI_DIV(2), .PLL_LOCK_CYC(4), .ROM_DEFAULT(ROM)) u_hbc_boot_seq (.clk(clk), .rst(rst),
      .ce(ce), .reset_n(reset_n), .nonremovable_strap(nr_det), .charging_strap(ch_det), .mode_do_pullup(mode_do),
      .mode_clk_pullup(mode_clk), .clk_valid(1'b1), .pll_locked(1'b1), .flash_dual(dual), .flash_cpol(cpol),
      .soc_wr(soc_wr), .soc_addr(soc_addr), .soc_data(soc_data), .otp_data(OTP), .otp_valid(otp_v), .vbus(vbus),
      .charger_detect_done(chg_done), .usb_configured(usb_cfg), .soft_disconnect(soft_disc), .flash_sck(sck),
      .flash_cs_n(cs_n), .flash_mosi(mosi), .flash_mosi_oe_n(moe_n), .flash_miso(io0), .flash_io1(io1),
      .pll_enable(pll_en), .ports_hiz(hiz), .nonremovable_code(nr_code), .charging_code(ch_code),
      .nonremovable_ports(nr_ports), .charging_ports(ch_ports), .smbus_mode(smb), .exec_external(exec_ext),
      .exec_addr(exec_addr), .final_cfg(final_cfg), .cfg_applied(applied), .suspend(susp),
      .charger_detect_stage(chg), .usb_attach(attach), .normal_mode(normal), .stage(stage));
   hbc_flash_model u_hbc_flash_model (.sck(sck), .cs_n(cs_n), .mosi(mosi), .io0(io0), .io1(io1), .dual(dual),
      .data(fdata), .hdr(hdr));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cs_n === 1'b0) cs_seen = 1'b1;
      if (cycles == 40000) begin
         n_errors = n_errors + 1;
         conclude;
      end
   end
   function [1:0] ecode(input [1:0] d);
      ecode = (d == 2'h3) ? 2'h0 : d;
   endfunction
   function [1:0] eports(input [1:0] c);
      eports = (c == 2'h0) ? 2'h0 : (c == 2'h1) ? 2'h1 : 2'h3;
   endfunction
   task conclude;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input reg ok, input [8*20-1:0] msg);
      n_compared = n_compared + 1;
      if (ok !== 1'b1) begin
         n_errors = n_errors + 1;
         $display("MISMATCH %0t %0s", $time, msg);
      end
   endtask
   task step;
      @(posedge clk);
      #1;
   endtask
   task wait_stage(input integer b);
      integer k;
      k = 0;
      while (stage[b] !== 1'b1 && k < 3000) begin
         step;
         k = k + 1;
      end
      chk(stage[b] === 1'b1, "stage not reached");
   endtask
   task boot(input [1:0] nr, input [1:0] ch, input sm, input dl, input cp, input [31:0] d);
      step;
      reset_n = 1'b0;
      {nr_det, ch_det, mode_do, mode_clk, dual, cpol, fdata, vbus} = {nr, ch, sm, sm, dl, cp, d, 1'b0};
      step;
      chk(stage === 11'h001 && hiz === 1'b1, "standby");
      chk(pll_en === 1'b0 && final_cfg === 16'h0 && cs_n === 1'b1 && moe_n === 1'b1, "defaults");
      reset_n = 1'b1;
      wait_stage(sm ? 5 : 7);
      chk(pll_en === 1'b1 && moe_n === 1'b1, "pll");
   endtask
   task soc_write(input [7:0] a, input [15:0] d);
      step;
      {soc_wr, soc_addr, soc_data} = {1'b1, a, d};
      step;
      soc_wr = 1'b0;
   endtask
   task t_spi(input [1:0] j);
      boot(2'h3 - j, j, 1'b0, j[0], j[1], (j == 2'h3) ? SIG ^ 32'h1 : SIG);
      chk(hdr === {j[0] ? `HBC_CMD_DREAD : `HBC_CMD_READ, 8'h00, `HBC_SIG_ADDR}, "header");
      chk(exec_ext === (j != 2'h3) && exec_addr === `HBC_EXEC_ADDR, "exec");
      chk(smb === 1'b0 && final_cfg === (ROM | OTP) && applied === 1'b1, "cfg");
      chk(nr_code === ecode(2'h3 - j) && ch_code === ecode(j), "code");
      chk(nr_ports === eports(ecode(2'h3 - j)) && ch_ports === eports(ecode(j)), "ports");
   endtask
   task t_flow(input [1:0] j);
      step;
      chk(susp === 1'b1 && stage[7] === 1'b1, "suspend");
      vbus = 1'b1;
      step;
      chk(stage === ((ecode(j) != 2'h0) ? 11'h100 : 11'h200), "vbus branch");
      chk(chg === (ecode(j) != 2'h0) && susp === 1'b0, "charger_detect_stage flag");
      chg_done = 1'b1;
      wait_stage(9);
      chg_done = 1'b0;
      step;
      step;
      chk(attach === 1'b1 && chg === 1'b0, "attach");
      usb_cfg = 1'b1;
      wait_stage(10);
      step;
      chk(normal === 1'b1, "normal");
      {soft_disc, usb_cfg} = 2'b10;
      step;
      chk(stage[9] === 1'b1, "soft disconnect");
      step;
      step;
      chk(attach === 1'b0, "detach");
      {soft_disc, vbus} = 2'b00;
      wait_stage(7);
   endtask
   task t_smbus;
      cs_seen = 1'b0;
      otp_v = 1'b0;
      boot(2'h0, 2'h0, 1'b1, 1'b0, 1'b0, SIG);
      repeat (50) step;
      chk(stage[5] === 1'b1 && cs_seen === 1'b0 && smb === 1'b1, "host wait");
      soc_write(8'h10, 16'h0C30);
      soc_write(8'hFF, 16'h0C30);
      chk(stage[6] === 1'b1, "merge");
      step;
      chk(stage[7] === 1'b1 && final_cfg === 16'h0C30 && hiz === 1'b0, "host cfg");
      otp_v = 1'b1;
   endtask
   task t_latch;
      {nr_det, ch_det} = 4'h9;
      repeat (3) step;
      chk(nr_code === 2'h0 && ch_code === 2'h0, "latched");
      // Clock enable low must hold the idle stage against a VBUS arrival
      ce = 1'b0;
      vbus = 1'b1;
      repeat (3) step;
      chk(stage[7] === 1'b1 && susp === 1'b1, "frozen");
      ce = 1'b1;
      step;
      chk(stage[9] === 1'b1 && susp === 1'b0, "thawed");
      vbus = 1'b0;
      step;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         t_spi(i[1:0]);
         t_flow(i[1:0]);
      end
      t_smbus;
      t_latch;
      conclude;
   end
endmodule
